// ==== logic/i2c_flags_pkg.sv ====
// shared constants for the two-wire status and interrupt block
package i2c_flags_pkg;
   // ==========================================================
   // register word offsets
   localparam int ADDR_W = 3;
   localparam logic [2:0] OFS_OWN = 3'h0;
   localparam logic [2:0] OFS_FREQ = 3'h1;
   localparam logic [2:0] OFS_CTRL = 3'h2;
   localparam logic [2:0] OFS_STAT = 3'h3;
   localparam logic [2:0] OFS_DATA = 3'h4;
   localparam logic [2:0] OFS_MASK = 3'h5;
   // ==========================================================
   // control fields
   localparam int CTL_EN = 7;
   localparam int CTL_IE = 6;
   localparam int CTL_MST = 5;
   localparam int CTL_TX = 4;
   localparam int CTL_TXAK = 3;
   localparam int CTL_RSTA = 2;
   localparam logic [7:0] CTRL_WMASK = 8'hf8;
   // ==========================================================
   // status fields
   localparam int ST_DONE = 7;
   localparam int ST_AAS = 6;
   localparam int ST_BUSY = 5;
   localparam int ST_ARB_LOST_FLAG = 4;
   localparam int ST_SRW = 2;
   localparam int ST_IRQF = 1;
   localparam int ST_RXAK = 0;
   localparam logic [7:0] STICKY = 8'hd2;
   // ==========================================================
   // reset values and bit counts
   localparam logic [7:0] RST_OWN = 8'h00;
   localparam logic [7:0] RST_FREQ = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hd2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_PRE = 4'hf;
   typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_SKIP} phase_e;
endpackage

// ==== logic/pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin,
   output logic level
);
   logic s1_ff, s2_ff, s3_ff, level_ff;

   // idle bus lines float high, so reset to one
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         level_ff <= 1'b1;
      end
      else
      begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff)
            level_ff <= s3_ff;
      end
   end

   assign level = level_ff;
endmodule

// ==== logic/bus_monitor.sv ====
// edge and start/stop detection on the synchronised bus lines
`timescale 1ns/1ns
module bus_monitor
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_seen,
   output logic stop_seen
);
   logic scl_q_ff, sda_q_ff;

   // previous line levels
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
      end
   end

   // sda moving while scl stays high marks start or stop
   assign scl_rise = scl & ~scl_q_ff;
   assign scl_fall = ~scl & scl_q_ff;
   assign start_seen = scl & scl_q_ff & sda_q_ff & ~sda;
   assign stop_seen = scl & scl_q_ff & ~sda_q_ff & sda;
endmodule

// ==== logic/i2c_status_irq.sv ====
// status flags, arbitration watch and interrupt of the two-wire bus unit
// ==========================================================
// Notes on behaviour
// RULE1: transfer-done flag sets at the falling edge of the ninth clock.
// RULE2: own-address match on a calling address sets the addressed flag.
// RULE3: address-match interrupt reaches the cpu only with interrupt enable set.
// RULE4: software reads the direction bit and sets transmit select to match.
// RULE5: lost arbitration sets its flag and raises the interrupt.
// RULE6: released data line read low while transmitting loses arbitration.
// RULE7: released ack bit read low while receiving loses arbitration.
// RULE8: start request on a busy bus loses arbitration.
// RULE9: repeated start requested in slave mode loses arbitration.
// RULE10: stop seen that this master did not request loses arbitration.
// RULE11: arbitration-lost flag holds until software writes one to it.
// RULE12: slave bring-up writes own address, then enable and interrupt enable.
// RULE13: master bring-up sets divider, enables, then sets master mode.
// RULE14: first data write as master gives direction by its lowest bit.
// RULE15: as slave, take part only after a matching calling address.
// RULE16: every source sets one common flag, gated by enable, cleared by one.
// RULE17: on loss go slave receive, release data line, no stop.
// RULE18: hardware clears master mode when arbitration is lost.
`timescale 1ns/1ns
module i2c_status_irq
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [i2c_flags_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic start_req,
   output logic stop_req
);
   import i2c_flags_pkg::*;

   logic scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen;
   logic ack_ff, wr_take, wr_ctrl;
   logic [31:0] readdata_ff;
   logic [7:0] own_ff, freq_ff, ctrl_ff, mask_ff, tx_sh_ff, rx_sh_ff, rx_byte_ff;
   logic done_ff, aas_ff, arb_lost_flag_ff, irqf_ff, busy_ff, srw_ff, rxak_ff;
   logic match_ff, master_rd_ff, stop_pend_ff, sda_bit_ff;
   logic start_req_ff, stop_req_ff;
   logic [3:0] bit_cnt_ff, nb;
   phase_e phase_ff;
   logic en, master_mode_sel, xmit, xmit_nxt, done_ev, match_ev, arb_ev;
   logic loss_line, loss_start, loss_rsta, loss_stop;
   logic [7:0] status, byte_in, w1c, rd_mux;

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ==========================================================
   // line sampling
   pin_sync u_scl_sync (.clk(clk), .rstn(rstn), .pin(scl_in), .level(scl_lvl));
   pin_sync u_sda_sync (.clk(clk), .rstn(rstn), .pin(sda_in), .level(sda_lvl));
   bus_monitor u_mon
   (
      .clk(clk),
      .rstn(rstn),
      .scl(scl_lvl),
      .sda(sda_lvl),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_seen(start_seen),
      .stop_seen(stop_seen)
   );

   // ==========================================================
   // register bus: one wait cycle, then the access completes
   assign waitrequest = (read | write) & ~ack_ff;
   assign wr_take = write & ack_ff;
   assign wr_ctrl = wr_take && address == OFS_CTRL;
   assign w1c = (wr_take && address == OFS_STAT) ? writedata[7:0] & STICKY : 8'h00;

   always_ff @(posedge clk)
   begin
      if (!rstn)
         ack_ff <= 1'b0;
      else
         ack_ff <= (read | write) & ~ack_ff;
   end

   // status image, reserved bit reads zero
   always_comb
   begin
      status = 8'h00;
      status[ST_DONE] = done_ff;
      status[ST_AAS] = aas_ff;
      status[ST_BUSY] = busy_ff;
      status[ST_ARB_LOST_FLAG] = arb_lost_flag_ff;
      status[ST_SRW] = srw_ff;
      status[ST_IRQF] = irqf_ff;
      status[ST_RXAK] = rxak_ff;
   end

   // read mux, unmapped words read zero
   always_comb
   begin
      case (address)
         OFS_OWN: rd_mux = own_ff;
         OFS_FREQ: rd_mux = freq_ff;
         OFS_CTRL: rd_mux = ctrl_ff;
         OFS_STAT: rd_mux = status;
         OFS_DATA: rd_mux = rx_byte_ff;
         OFS_MASK: rd_mux = mask_ff;
         default: rd_mux = 8'h00;
      endcase
   end

   // read data captured in the wait cycle so it stands at completion
   always_ff @(posedge clk)
   begin
      if (!rstn)
         readdata_ff <= 32'h0000_0000;
      else if (read && !ack_ff)
         readdata_ff <= {24'h00_0000, rd_mux};
   end
   assign readdata = readdata_ff;

   // plain software registers
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         own_ff <= RST_OWN;
         freq_ff <= RST_FREQ;
         mask_ff <= RST_MASK;
         tx_sh_ff <= RST_BYTE;
      end
      else if (wr_take)
      begin
         if (address == OFS_OWN)
            own_ff <= writedata[7:0];
         if (address == OFS_FREQ)
            freq_ff <= writedata[7:0];
         if (address == OFS_MASK)
            mask_ff <= writedata[7:0] & STICKY;
         if (address == OFS_DATA)
            tx_sh_ff <= writedata[7:0];
      end
   end

   // control: arbitration loss overrides a write in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl_ff <= RST_CTRL;
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= writedata[7:0] & CTRL_WMASK;
         if (arb_ev)
         begin
            ctrl_ff[CTL_MST] <= 1'b0; // RULE18
            ctrl_ff[CTL_TX] <= 1'b0; // RULE17
         end
      end
   end

   assign en = ctrl_ff[CTL_EN];
   assign master_mode_sel = ctrl_ff[CTL_MST];

   // ==========================================================
   // byte tracking
   assign byte_in = {rx_sh_ff[6:0], sda_lvl};
   assign nb = (bit_cnt_ff == BIT_ACK) ? 4'h0 : bit_cnt_ff + 4'h1;
   assign xmit = master_mode_sel ? (phase_ff == PH_ADDR || !master_rd_ff)
                     : (phase_ff == PH_DATA && ctrl_ff[CTL_TX]);
   // direction of the first data byte follows the address phase outcome
   assign xmit_nxt = (bit_cnt_ff == BIT_ACK && phase_ff == PH_ADDR)
                     ? (master_mode_sel ? !master_rd_ff : match_ff && ctrl_ff[CTL_TX]) : xmit;
   assign match_ev = en && scl_rise && phase_ff == PH_ADDR && !master_mode_sel
                     && bit_cnt_ff == BIT_LAST && byte_in[7:1] == own_ff[7:1];
   assign done_ev = en && scl_fall && bit_cnt_ff == BIT_ACK
                    && (master_mode_sel || phase_ff == PH_DATA || match_ff);

   // phase and bit counter; counting starts at the fall after start
   always_ff @(posedge clk)
   begin
      if (!rstn || !en)
      begin
         phase_ff <= PH_IDLE;
         bit_cnt_ff <= BIT_PRE;
         match_ff <= 1'b0;
      end
      else if (start_seen)
      begin
         phase_ff <= PH_ADDR;
         bit_cnt_ff <= BIT_PRE;
         match_ff <= 1'b0;
      end
      else if (stop_seen)
         phase_ff <= PH_IDLE;
      else
      begin
         if (match_ev)
            match_ff <= 1'b1; // RULE2
         if (scl_fall && phase_ff != PH_IDLE)
         begin
            bit_cnt_ff <= nb;
            if (bit_cnt_ff == BIT_ACK)
            begin
               unique case (phase_ff)
                  PH_ADDR: phase_ff <= (master_mode_sel || match_ff) ? PH_DATA : PH_SKIP; // RULE15
                  PH_IDLE, PH_DATA, PH_SKIP: phase_ff <= phase_ff;
               endcase
            end
         end
      end
   end

   // receive shifter, ack sample and completed byte
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rx_sh_ff <= RST_BYTE;
         rx_byte_ff <= RST_BYTE;
         rxak_ff <= 1'b0;
         srw_ff <= 1'b0;
      end
      else
      begin
         if (scl_rise && bit_cnt_ff <= BIT_LAST)
            rx_sh_ff <= byte_in;
         if (scl_rise && bit_cnt_ff == BIT_ACK)
            rxak_ff <= sda_lvl;
         if (done_ev)
            rx_byte_ff <= rx_sh_ff;
         if (match_ev)
            srw_ff <= byte_in[0]; // RULE2
      end
   end

   // direction of a master transfer from the address byte
   always_ff @(posedge clk)
   begin
      if (!rstn)
         master_rd_ff <= 1'b0;
      else if (wr_take && address == OFS_DATA && master_mode_sel && phase_ff != PH_DATA)
         master_rd_ff <= writedata[0]; // RULE14
   end

   // data line: open drain, only ever pulled low
   always_ff @(posedge clk)
   begin
      if (!rstn || !en || arb_ev || start_seen || stop_seen)
         sda_bit_ff <= 1'b1; // RULE17
      else if (scl_fall && phase_ff != PH_IDLE && phase_ff != PH_SKIP)
      begin
         if (nb == BIT_ACK)
            sda_bit_ff <= xmit ? 1'b1 : (phase_ff == PH_ADDR ? !match_ff : ctrl_ff[CTL_TXAK]);
         else
            sda_bit_ff <= xmit_nxt ? tx_sh_ff[3'(BIT_LAST - nb)] : 1'b1;
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = ~sda_bit_ff;

   // ==========================================================
   // arbitration loss sources
   assign loss_line = master_mode_sel && scl_rise && sda_bit_ff && !sda_lvl
                      && (bit_cnt_ff == BIT_ACK ? !xmit // RULE7
                          : xmit && bit_cnt_ff <= BIT_LAST); // RULE6
   assign loss_start = wr_ctrl && writedata[CTL_MST] && !master_mode_sel && busy_ff; // RULE8
   assign loss_rsta = wr_ctrl && writedata[CTL_RSTA] && !master_mode_sel; // RULE9
   assign loss_stop = stop_seen && master_mode_sel && !stop_pend_ff; // RULE10
   assign arb_ev = en && (loss_line || loss_start || loss_rsta || loss_stop);

   // start and stop requests toward the waveform generator
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         start_req_ff <= 1'b0;
         stop_req_ff <= 1'b0;
         stop_pend_ff <= 1'b0;
      end
      else
      begin
         start_req_ff <= en && wr_ctrl && !loss_start
                         && ((writedata[CTL_MST] && !master_mode_sel) || (writedata[CTL_RSTA] && master_mode_sel));
         stop_req_ff <= en && wr_ctrl && !writedata[CTL_MST] && master_mode_sel && !arb_ev;
         if (!en || stop_seen)
            stop_pend_ff <= 1'b0;
         else if (en && wr_ctrl && !writedata[CTL_MST] && master_mode_sel)
            stop_pend_ff <= 1'b1;
      end
   end
   assign start_req = start_req_ff;
   assign stop_req = stop_req_ff;

   // bus busy tracks every master, enabled or not
   always_ff @(posedge clk)
   begin
      if (!rstn)
         busy_ff <= 1'b0;
      else if (start_seen)
         busy_ff <= 1'b1;
      else if (stop_seen)
         busy_ff <= 1'b0;
   end

   // ==========================================================
   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         done_ff <= 1'b0;
         aas_ff <= 1'b0;
         arb_lost_flag_ff <= 1'b0;
         irqf_ff <= 1'b0;
      end
      else
      begin
         done_ff <= (done_ff & ~w1c[ST_DONE]) | done_ev; // RULE1
         aas_ff <= (aas_ff & ~w1c[ST_AAS]) | match_ev; // RULE2
         arb_lost_flag_ff <= (arb_lost_flag_ff & ~w1c[ST_ARB_LOST_FLAG]) | arb_ev; // RULE5 RULE11
         irqf_ff <= (irqf_ff & ~w1c[ST_IRQF]) | done_ev | match_ev | arb_ev; // RULE16
      end
   end

   // level interrupt, gated by the interrupt enable bit and the mask
   assign irq = ctrl_ff[CTL_IE] && |(status & mask_ff); // RULE3 RULE16

   // ==========================================================
   // checks
   a_done_ninth: // RULE1
      assert property (done_ev |=> done_ff && irqf_ff)
      else $error("done flag missed at ninth clock fall");
   a_match_flag: // RULE2
      assert property (match_ev |=> aas_ff && srw_ff == $past(byte_in[0]))
      else $error("address match did not set flags");
   a_irq_gate: // RULE3
      assert property (!ctrl_ff[CTL_IE] |-> !irq)
      else $error("interrupt raised while disabled");
   a_aas_irq: // RULE3
      assert property ($rose(aas_ff) && ctrl_ff[CTL_IE] && mask_ff[ST_AAS] |-> irq)
      else $error("address match interrupt missing");
   a_arb_flag: // RULE5
      assert property (arb_ev && ctrl_ff[CTL_IE] && mask_ff[ST_ARB_LOST_FLAG] |=> arb_lost_flag_ff && irq)
      else $error("arbitration loss not signalled");
   a_line_loss: // RULE6
      assert property (en && master_mode_sel && scl_rise && sda_bit_ff && !sda_lvl && xmit
                       && bit_cnt_ff < BIT_ACK |=> arb_lost_flag_ff)
      else $error("transmit arbitration loss missed");
   a_ack_loss: // RULE7
      assert property (en && master_mode_sel && scl_rise && sda_bit_ff && !sda_lvl && !xmit
                       && bit_cnt_ff == BIT_ACK |=> arb_lost_flag_ff)
      else $error("ack arbitration loss missed");
   a_busy_start: // RULE8
      assert property (en && wr_ctrl && writedata[CTL_MST] && !master_mode_sel && busy_ff
                       |=> arb_lost_flag_ff && !start_req)
      else $error("start on busy bus not refused");
   a_rsta_slave: // RULE9
      assert property (en && wr_ctrl && writedata[CTL_RSTA] && !master_mode_sel |=> arb_lost_flag_ff)
      else $error("repeated start in slave mode not flagged");
   a_stray_stop: // RULE10
      assert property (en && stop_seen && master_mode_sel && !stop_pend_ff |=> arb_lost_flag_ff ##1 arb_lost_flag_ff)
      else $error("unrequested stop not flagged");
   a_arb_lost_flag_held: // RULE11
      assert property (arb_lost_flag_ff && !w1c[ST_ARB_LOST_FLAG] |=> arb_lost_flag_ff)
      else $error("arbitration flag dropped without clear");
   a_arb_lost_flag_quiet: // RULE11
      assert property (!arb_lost_flag_ff && !arb_ev |=> !arb_lost_flag_ff)
      else $error("arbitration flag set without cause");
   a_dir_lsb: // RULE14
      assert property (wr_take && address == OFS_DATA && master_mode_sel && phase_ff != PH_DATA
                       |=> master_rd_ff == $past(writedata[0]))
      else $error("direction not taken from address lsb");
   a_no_stray_ack: // RULE15
      assert property (scl_fall && phase_ff == PH_ADDR && !master_mode_sel && !match_ff
                       && nb == BIT_ACK |=> !sda_oe)
      else $error("acknowledged a foreign address");
   a_common_flag: // RULE16
      assert property (done_ev || match_ev |=> irqf_ff)
      else $error("common flag not set");
   a_loss_release: // RULE17 RULE18
      assert property (arb_ev |=> !sda_oe && !master_mode_sel && !ctrl_ff[CTL_TX] && !stop_req)
      else $error("no fall back to slave receive after loss");
endmodule

// ==== test/bus_peer.sv ====
// far-side party on the two-wire bus: competing master and caller
`timescale 1ns/1ns
module bus_peer
(
   output logic scl_low,
   output logic sda_low,
   input wire logic sda
);
   // ==========================================================
   // idle bus: both lines released, clock stands still between frames
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // tasks start on a rising block clock edge; every line change keeps
   // at least 10 ns away from those edges so the synchroniser sees no race
   // start: data falls while the clock is high, then the clock goes low
   task automatic start_cond();
      #20 sda_low = 1'b1;
      #300 scl_low = 1'b1;
      #180;
   endtask
   // stop from a low clock: data held low, clock released, data released
   task automatic stop_cond();
      #20 sda_low = 1'b1;
      #200 scl_low = 1'b0;
      #300 sda_low = 1'b0;
      #480;
   endtask
   // start directly followed by stop while the clock stays high
   task automatic start_stop();
      #20 sda_low = 1'b1;
      #300 sda_low = 1'b0;
      #680;
   endtask
   // nine bits msb first, 800 ns each; ack is the ninth sample
   // long low phase so the block's delayed drive settles before the rise
   task automatic send_bits(input logic [8:0] bits, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         #20 sda_low = ~bits[i];
         #330 scl_low = 1'b0;
         #200 ack = sda;
         #40 scl_low = 1'b1;
         #210;
      end
      #600;
   endtask
   // a byte with its ninth bit released for the block to answer
   task automatic send_byte(input logic [7:0] b, output logic ack);
      send_bits({b, 1'b1}, ack);
   endtask
endmodule

// ==== test/i2c_status_interrupt_flags_tb.sv ====
// self-checking bench for the two-wire status and interrupt block
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         failures++; \
         $display("BAD %s exp %h got %h", nm, e, g); \
      end \
   end
module i2c_status_interrupt_flags_tb;
   import i2c_flags_pkg::*;
   logic clk;
   logic rstn;
   logic [ADDR_W-1:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq;
   logic dut_sda_out;
   logic dut_sda_oe;
   logic start_req;
   logic stop_req;
   logic peer_scl_low;
   logic peer_sda_low;
   logic [7:0] n_start;
   logic [7:0] n_stop;
   int total_checks;
   int failures;
   // ==========================================================
   // open-drain wires with pull-ups
   wire scl_wire = ~peer_scl_low;
   wire sda_wire = ~(peer_sda_low | dut_sda_oe);

   i2c_status_irq dut
   (
      .clk(clk),
      .rstn(rstn),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .irq(irq),
      .scl_in(scl_wire),
      .sda_in(sda_wire),
      .sda_out(dut_sda_out),
      .sda_oe(dut_sda_oe),
      .start_req(start_req),
      .stop_req(stop_req)
   );
   bus_peer peer
   (
      .scl_low(peer_scl_low),
      .sda_low(peer_sda_low),
      .sda(sda_wire)
   );
   // ==========================================================
   // clock, reset and request pulse counters
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (start_req === 1'b1)
         n_start <= n_start + 8'd1;
      if (stop_req === 1'b1)
         n_stop <= n_stop + 8'd1;
   end
   // ==========================================================
   // bus access: request held until waitrequest is sampled low
   task automatic bus_op(input logic wr, input logic [2:0] a, input logic [7:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= {24'h000000, d};
      // no cycle count assumed: only the watchdog ends a hung wait
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0);
      // one wait edge, then the completing edge
      `CHK("wait edges", 2, n)
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus_op(1'b1, a, d, q);
   endtask
   // masked read compare, expectation already masked
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
      input string nm);
      logic [31:0] q;
      bus_op(1'b0, a, 8'h00, q);
      `CHK(nm, e, q[7:0] & m)
   endtask
   // let the register update of the last access land before looking
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      `CHK("irq", e, irq)
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // watchdog, well above the roughly 60 us the sequence needs
   initial
   begin
      #300000;
      failures++;
      stop_test();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      logic ack;
      rstn = 1'b0;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      n_start = 8'h00;
      n_stop = 8'h00;
      total_checks = 0;
      failures = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      // reset values and an unmapped word
      rd_chk(OFS_CTRL, 8'hff, RST_CTRL, "ctrl");
      rd_chk(OFS_MASK, 8'hff, RST_MASK, "mask");
      rd_chk(OFS_OWN, 8'hff, RST_OWN, "own");
      rd_chk(OFS_STAT, 8'hff, 8'h00, "stat");
      rd_chk(3'h6, 8'hff, 8'h00, "unmapped");
      // matching call while the interrupt enable is still off
      bus_wr(OFS_OWN, 8'h54);
      bus_wr(OFS_CTRL, 8'h80);
      peer.start_cond();
      peer.send_byte(8'h55, ack);
      `CHK("match ack", 1'b0, ack)
      rd_chk(OFS_STAT, 8'hfe, 8'he6, "stat match");
      irq_chk(1'b0);
      // direction bit read as one, so transmit select follows it
      bus_wr(OFS_CTRL, 8'hd0);
      irq_chk(1'b1);
      bus_wr(OFS_STAT, 8'hd2);
      rd_chk(OFS_STAT, 8'hd2, 8'h00, "stat cleared");
      irq_chk(1'b0);
      peer.stop_cond();
      rd_chk(OFS_STAT, 8'h20, 8'h00, "busy after stop");
      // a foreign address is neither answered nor flagged
      peer.start_cond();
      peer.send_byte(8'h20, ack);
      `CHK("foreign ack", 1'b1, ack)
      rd_chk(OFS_STAT, 8'hc0, 8'h00, "stat foreign");
      // master mode asked for while that frame still holds the bus
      bus_wr(OFS_CTRL, 8'he0);
      rd_chk(OFS_STAT, 8'h32, 8'h32, "busy start");
      rd_chk(OFS_CTRL, 8'hff, 8'hc0, "ctrl loss");
      irq_chk(1'b1);
      `CHK("no start", 8'h00, n_start)
      bus_wr(OFS_STAT, 8'h02);
      rd_chk(OFS_STAT, 8'h10, 8'h10, "arb_lost_flag held");
      irq_chk(1'b1);
      bus_wr(OFS_STAT, 8'h10);
      rd_chk(OFS_STAT, 8'h12, 8'h00, "arb_lost_flag cleared");
      peer.stop_cond();
      // repeated start in slave mode, then the mask register
      bus_wr(OFS_CTRL, 8'hc4);
      rd_chk(OFS_STAT, 8'h10, 8'h10, "arb_lost_flag rsta");
      bus_wr(OFS_MASK, 8'hff);
      rd_chk(OFS_MASK, 8'hff, 8'hd2, "mask kept");
      bus_wr(OFS_MASK, 8'h00);
      irq_chk(1'b0);
      bus_wr(OFS_MASK, 8'hd2);
      irq_chk(1'b1);
      bus_wr(OFS_STAT, 8'hd2);
      irq_chk(1'b0);
      // master bring-up, then a stop this master never asked for
      bus_wr(OFS_FREQ, 8'h1f);
      rd_chk(OFS_FREQ, 8'hff, 8'h1f, "divider");
      bus_wr(OFS_CTRL, 8'he0);
      repeat (3) @(posedge clk);
      `CHK("start pulse", 8'h01, n_start)
      peer.start_stop();
      rd_chk(OFS_STAT, 8'h10, 8'h10, "arb_lost_flag stop");
      rd_chk(OFS_CTRL, 8'h20, 8'h00, "mst dropped");
      bus_wr(OFS_STAT, 8'hd2);
      // transmitting master releases data and the peer pulls it low
      bus_wr(OFS_CTRL, 8'hf0);
      bus_wr(OFS_DATA, 8'hff);
      peer.start_cond();
      peer.send_byte(8'h00, ack);
      rd_chk(OFS_STAT, 8'h12, 8'h12, "arb_lost_flag tx");
      rd_chk(OFS_CTRL, 8'h30, 8'h00, "slave rx");
      `CHK("sda released", 1'b0, dut_sda_oe)
      `CHK("no stop", 8'h00, n_stop)
      `CHK("start count", 8'h02, n_start)
      irq_chk(1'b1);
      peer.stop_cond();
      // receiving master leaves its ack bit released and the peer pulls it low
      bus_wr(OFS_STAT, 8'hd2);
      bus_wr(OFS_CTRL, 8'he8);
      bus_wr(OFS_DATA, 8'ha5);
      peer.start_cond();
      peer.send_byte(8'ha5, ack);
      peer.send_bits({8'h3c, 1'b0}, ack);
      rd_chk(OFS_STAT, 8'h90, 8'h90, "arb_lost_flag ack");
      rd_chk(OFS_DATA, 8'hff, 8'h3c, "rx byte");
      rd_chk(OFS_CTRL, 8'h20, 8'h00, "mst ack loss");
      `CHK("no stop rx", 8'h00, n_stop)
      `CHK("start count rx", 8'h03, n_start)
      `CHK("sda out", 1'b0, dut_sda_out)
      peer.stop_cond();
      stop_test();
   end
endmodule
